// ---- hw/vst_acc_dec.sv ----
`timescale 1ns/1ns
module vst_acc_dec (
  input wire logic clk_i,
  input wire logic rstn_i,
  vst_acc_if.dec acc
);
  import vst_pkg::*;

  always_comb begin
    acc.sel = '0;
    unique case (acc.addr)
      OFF_VS1_UP: acc.sel[0] = 1'b1;
      OFF_VS2_UP: acc.sel[1] = 1'b1;
      OFF_VS3_UP: acc.sel[2] = 1'b1;
      OFF_VS4_UP: acc.sel[3] = 1'b1;
      OFF_VS5_UP: acc.sel[4] = 1'b1;
      OFF_MEMBER_VEC: acc.sel[SEL_VEC] = 1'b1;
      OFF_LAUNCH: acc.sel[SEL_LAUNCH] = 1'b1;
      default: acc.sel = '0;
    endcase
  end

  // a blocked path is a no-op: no write, read answers zero
  assign acc.wr_en = acc.req & acc.wr & acc.path_ok;
  assign acc.rd_en = acc.req & ~acc.wr & acc.path_ok;

  blocked_no_write_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !acc.path_ok |-> !acc.wr_en && !acc.rd_en)
    else $error("access through a foreign upstream port was enabled");

  sel_onehot_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    $onehot0(acc.sel))
    else $error("register select is not one-hot");

endmodule : vst_acc_dec

// ---- hw/vst_acc_if.sv ----
`timescale 1ns/1ns
interface vst_acc_if;
  import vst_pkg::*;
  logic req;
  logic wr;
  logic path_ok;
  logic [ADDR_W-1:0] addr;
  logic [NUM_SEL-1:0] sel;
  logic wr_en;
  logic rd_en;

  modport core (output req, output wr, output path_ok, output addr,
                input sel, input wr_en, input rd_en);
  modport dec (input req, input wr, input path_ok, input addr,
               output sel, output wr_en, output rd_en);
endinterface : vst_acc_if

// ---- hw/vst_pkg.sv ----
package vst_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int UP_W = 5;
  localparam int NUM_UP = 5;
  localparam int NUM_SEL = 7;

  // byte offsets
  localparam logic [ADDR_W-1:0] OFF_VS1_UP = 12'h364;
  localparam logic [ADDR_W-1:0] OFF_VS2_UP = 12'h368;
  localparam logic [ADDR_W-1:0] OFF_VS3_UP = 12'h36c;
  localparam logic [ADDR_W-1:0] OFF_VS4_UP = 12'h370;
  localparam logic [ADDR_W-1:0] OFF_VS5_UP = 12'h374;
  localparam logic [ADDR_W-1:0] OFF_MEMBER_VEC = 12'h380;
  localparam logic [ADDR_W-1:0] OFF_LAUNCH = 12'h3ac;

  // select indices
  localparam int SEL_VEC = 5;
  localparam int SEL_LAUNCH = 6;

  // field layout
  localparam int UP_LSB = 0;
  localparam int LAUNCH_BIT = 0;
  localparam logic [DATA_W-1:0] UP_RW_MASK = 32'h0000_001f;
  localparam logic [DATA_W-1:0] VEC_RW_MASK = 32'h0000_0f0f;
  localparam logic [DATA_W-1:0] LAUNCH_RW_MASK = 32'h0000_0001;

  // reset values
  localparam logic [DATA_W-1:0] VEC_ALL_PORTS = 32'h00ff_ffff;
  localparam logic [UP_W-1:0] UP_NT_DISABLED = 5'h1f;
  localparam logic [UP_W-1:0] UP_RESERVED_CODE = 5'h00;
  // member flags per test-mode strap code; plain defaults
  localparam logic [DATA_W-1:0] VEC_TM_RST [8] = '{
    32'h0000_0f0f, 32'h0000_0003, 32'h0000_0005, 32'h0000_0009,
    32'h0000_0101, 32'h0000_0201, 32'h0000_0401, 32'h0000_0801};

  // three-state strap pin codes
  localparam logic [1:0] TRI_LO = 2'h0;
  localparam logic [1:0] TRI_HI = 2'h1;
  localparam logic [1:0] TRI_Z = 2'h2;

  typedef enum logic [1:0] {
    VST_LOAD = 2'b01,
    VST_RUN = 2'b10
  } vst_state_type;

  // per pin: float wins over level
  function automatic logic [5:0] vst_tri(input logic [2:0] lvl,
                                         input logic [2:0] flt);
    logic [5:0] key;
    key = '0;
    for (int i = 0; i < 3; i++) begin
      key[2*i +: 2] = flt[i] ? TRI_Z : (lvl[i] ? TRI_HI : TRI_LO);
    end
    return key;
  endfunction : vst_tri

  function automatic logic [UP_W-1:0] vst_port_sel(input logic [5:0] key);
    logic [UP_W-1:0] port;
    port = UP_RESERVED_CODE;
    // key is {pin2, pin1, pin0}
    unique case (key)
      {TRI_LO, TRI_LO, TRI_LO}: port = 5'h00;
      {TRI_LO, TRI_LO, TRI_Z}: port = 5'h01;
      {TRI_LO, TRI_LO, TRI_HI}: port = 5'h02;
      {TRI_LO, TRI_Z, TRI_LO}: port = 5'h03;
      {TRI_LO, TRI_HI, TRI_HI}: port = 5'h08;
      {TRI_Z, TRI_LO, TRI_LO}: port = 5'h09;
      {TRI_Z, TRI_LO, TRI_Z}: port = 5'h0a;
      {TRI_Z, TRI_LO, TRI_HI}: port = 5'h0b;
      {TRI_Z, TRI_HI, TRI_Z}: port = 5'h10;
      {TRI_Z, TRI_HI, TRI_HI}: port = 5'h11;
      {TRI_HI, TRI_LO, TRI_LO}: port = 5'h12;
      {TRI_HI, TRI_LO, TRI_Z}: port = 5'h13;
      {TRI_HI, TRI_HI, TRI_HI}: port = UP_NT_DISABLED;
      default: port = UP_RESERVED_CODE;
    endcase
    return port;
  endfunction : vst_port_sel

endpackage : vst_pkg

// ---- hw/vst_regs.sv ----
// Function
// - switches 1-5 upstream: sticky RW port in bits 4:0, rest read zero
// - upstream reset value decoded from the nontransparent select strap
// - base mode: switch 0 membership vector defaults to 00FF_FFFF
// - switch mode: vector default from test-mode strap and mode input
// - switch mode, launch clear after reset: vector reads 00FF_FFFF
// - launch clear after reset if I2C strap low or mgmt strap floats
// - switch mode access via a non-management upstream port: read zero, no write
// - table formed from the enable input and the upstream and membership registers
// - in switch mode registers reachable only via the management port or EEPROM
`timescale 1ns/1ns
module vst_regs (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic hot_reset_i,
  // straps and mode inputs
  input wire logic i2c_config_allow_strap_n_i,
  input wire logic management_port_enable_strap_z_i,
  input wire logic [2:0] nontransparent_uplink_select_strap_i,
  input wire logic [2:0] nontransparent_uplink_select_strap_z_i,
  input wire logic [2:0] test_mode_strap_i,
  input wire logic virtual_switch_mode_input_i,
  input wire logic virtual_switch_mode_input_z_i,
  // register access port
  input wire logic cfg_req_i,
  input wire logic cfg_wr_i,
  input wire logic [vst_pkg::ADDR_W-1:0] cfg_addr_i,
  input wire logic [vst_pkg::DATA_W-1:0] cfg_wdata_i,
  input wire logic cfg_via_mgmt_i,
  input wire logic cfg_from_eeprom_i,
  output logic cfg_ack_o,
  output logic [vst_pkg::DATA_W-1:0] cfg_rdata_o,
  // applied virtual switch table
  input wire logic [5:0] virtual_switch_enable_bit_i,
  output logic [vst_pkg::NUM_UP*vst_pkg::UP_W-1:0] table_upstream_o,
  output logic [vst_pkg::DATA_W-1:0] table_members_o,
  output logic [5:0] table_enable_o,
  output logic launched_o,
  output logic virtual_switch_mode_input_o
);
  import vst_pkg::*;

  vst_acc_if acc ();

  vst_state_type state_reg;
  logic [UP_W-1:0] up_reg [NUM_UP];
  logic [DATA_W-1:0] vec_reg;
  logic launch_reg;
  logic launch_prev_reg;
  logic virtual_switch_mode_input_reg;
  logic virtual_switch_mode_input_next;
  logic launch_next;
  logic [UP_W-1:0] up_next;
  logic [DATA_W-1:0] vec_next;
  logic [DATA_W-1:0] rd_word;
  logic apply;

  assign acc.req = cfg_req_i & (state_reg == VST_RUN);
  assign acc.wr = cfg_wr_i;
  assign acc.addr = cfg_addr_i;
  // base mode: port 0 open; Virtual_switch_mode_input: management port or EEPROM only
  assign acc.path_ok = ~virtual_switch_mode_input_reg | cfg_via_mgmt_i |
                       cfg_from_eeprom_i;

  vst_acc_dec u_dec (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .acc(acc)
  );

  // a floating mode pin reads as base mode
  assign virtual_switch_mode_input_next = virtual_switch_mode_input_i &
                        ~virtual_switch_mode_input_z_i;
  assign launch_next = ~(~i2c_config_allow_strap_n_i |
                         management_port_enable_strap_z_i);
  assign up_next = vst_port_sel(vst_tri(
                   nontransparent_uplink_select_strap_i,
                   nontransparent_uplink_select_strap_z_i));

  always_comb begin
    if (!virtual_switch_mode_input_next) begin
      vec_next = VEC_ALL_PORTS;
    end else if (!launch_next) begin
      vec_next = VEC_ALL_PORTS;
    end else begin
      vec_next = VEC_TM_RST[test_mode_strap_i];
    end
  end

  // straps are caught on the first enabled edge after release, never inside the reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg <= VST_LOAD;
    end else if (ce_i) begin
      unique case (state_reg)
        VST_LOAD: state_reg <= VST_RUN;
        VST_RUN: state_reg <= VST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      virtual_switch_mode_input_reg <= 1'b0;
    end else if (ce_i && state_reg == VST_LOAD) begin
      virtual_switch_mode_input_reg <= virtual_switch_mode_input_next;
    end
  end

  // sticky: only the fundamental reset, loads and register writes touch these
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NUM_UP; i++) begin
        up_reg[i] <= '0;
      end
    end else if (ce_i) begin
      for (int i = 0; i < NUM_UP; i++) begin
        if (state_reg == VST_LOAD) begin
          up_reg[i] <= up_next;
        end else if (acc.wr_en && acc.sel[i]) begin
          up_reg[i] <= cfg_wdata_i[UP_LSB +: UP_W];
        end
      end
    end
  end

  // reserved, test and upper bits keep their load value
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      vec_reg <= '0;
    end else if (ce_i) begin
      if (state_reg == VST_LOAD) begin
        vec_reg <= vec_next;
      end else if (acc.wr_en && acc.sel[SEL_VEC]) begin
        vec_reg <= (vec_reg & ~VEC_RW_MASK) |
                   (cfg_wdata_i & VEC_RW_MASK);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      launch_reg <= 1'b0;
    end else if (ce_i) begin
      if (state_reg == VST_LOAD) begin
        launch_reg <= launch_next;
      end else if (acc.wr_en && acc.sel[SEL_LAUNCH]) begin
        launch_reg <= cfg_wdata_i[LAUNCH_BIT];
      end
    end
  end

  always_comb begin
    rd_word = '0;
    for (int i = 0; i < NUM_UP; i++) begin
      if (acc.sel[i]) begin
        rd_word = DATA_W'(up_reg[i]) & UP_RW_MASK;
      end
    end
    if (acc.sel[SEL_VEC]) begin
      rd_word = vec_reg;
    end
    if (acc.sel[SEL_LAUNCH]) begin
      rd_word = DATA_W'(launch_reg) & LAUNCH_RW_MASK;
    end
  end

  // one-cycle answer to every request in VST_RUN with ce_i high; blocked or unmapped reads give 0
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cfg_ack_o <= 1'b0;
      cfg_rdata_o <= '0;
    end else if (ce_i) begin
      cfg_ack_o <= acc.req;
      cfg_rdata_o <= acc.rd_en ? rd_word : '0;
    end
  end

  // the switch core sees a new table only on launch or hot reset
  // launch is edge-detected, so a strap-set bit still applies once
  assign apply = (state_reg == VST_RUN) &&
                 ((launch_reg && !launch_prev_reg) || hot_reset_i);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      launch_prev_reg <= 1'b0;
      launched_o <= 1'b0;
      virtual_switch_mode_input_o <= 1'b0;
    end else if (ce_i) begin
      launch_prev_reg <= launch_reg;
      launched_o <= launch_reg;
      virtual_switch_mode_input_o <= virtual_switch_mode_input_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      table_upstream_o <= '0;
      table_members_o <= '0;
      table_enable_o <= '0;
    end else if (ce_i && apply) begin
      for (int i = 0; i < NUM_UP; i++) begin
        table_upstream_o[i*UP_W +: UP_W] <= up_reg[i];
      end
      table_members_o <= vec_reg;
      table_enable_o <= virtual_switch_enable_bit_i;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  base_vector_default_a: assert property (
    (state_reg == VST_LOAD && ce_i && !virtual_switch_mode_input_next)
    |=> vec_reg == VEC_ALL_PORTS)
    else $error("base mode vector default wrong");

  unlaunched_vector_a: assert property (
    (state_reg == VST_LOAD && ce_i && virtual_switch_mode_input_next && !launch_next)
    |=> vec_reg == VEC_ALL_PORTS && !launch_reg)
    else $error("unlaunched virtual_switch_mode_input vector not all ports");

  launch_strap_a: assert property (
    (state_reg == VST_LOAD && ce_i && !i2c_config_allow_strap_n_i)
    |=> !launch_reg)
    else $error("launch bit set although i2c config strap low");

  upstream_strap_a: assert property (
    (state_reg == VST_LOAD && ce_i) |=> up_reg[0] == $past(up_next))
    else $error("upstream default not from strap");

  upstream_write_a: assert property (
    (acc.wr_en && acc.sel[1] && ce_i)
    |=> up_reg[1] == $past(cfg_wdata_i[UP_LSB +: UP_W]))
    else $error("upstream write not stored");

  foreign_read_zero_a: assert property (
    (cfg_req_i && !cfg_wr_i && !acc.path_ok && ce_i)
    |=> cfg_ack_o == $past(state_reg == VST_RUN) && cfg_rdata_o == '0)
    else $error("foreign port read returned data");

  foreign_write_none_a: assert property (
    (state_reg == VST_RUN && cfg_req_i && cfg_wr_i && !acc.path_ok)
    |=> $stable(vec_reg) && $stable(launch_reg))
    else $error("foreign port write changed a register");

  vector_fixed_bits_a: assert property (
    (state_reg == VST_RUN) |=>
    (vec_reg & ~VEC_RW_MASK) == $past(vec_reg & ~VEC_RW_MASK))
    else $error("fixed vector bits changed");

  sticky_hot_reset_a: assert property (
    (hot_reset_i && state_reg == VST_RUN && !acc.wr_en)
    |=> $stable(vec_reg) && up_reg[4] == $past(up_reg[4]))
    else $error("sticky field lost on hot reset");

  table_apply_a: assert property (
    (ce_i && apply) |=> table_members_o == $past(vec_reg) &&
    table_enable_o == $past(virtual_switch_enable_bit_i))
    else $error("table not applied");

  table_upstream_a: assert property (
    (ce_i && apply) |=>
    table_upstream_o[UP_W-1:0] == $past(up_reg[0]) &&
    table_upstream_o[NUM_UP*UP_W-1 -: UP_W] == $past(up_reg[NUM_UP-1]))
    else $error("upstream ports not applied");

  // hot reset only re-applies; the sticky fields are never cleared by it
  table_hold_a: assert property (
    !(ce_i && apply) |=>
    $stable(table_members_o) && $stable(table_upstream_o))
    else $error("table changed without launch or hot reset");

  vector_strap_a: assert property (
    (state_reg == VST_LOAD && ce_i && virtual_switch_mode_input_next && launch_next)
    |=> vec_reg == VEC_TM_RST[$past(test_mode_strap_i)])
    else $error("switch mode vector default not from strap");

  upstream_rsvd_zero_a: assert property (
    (ce_i && acc.rd_en && (|acc.sel[NUM_UP-1:0]))
    |=> cfg_rdata_o[DATA_W-1:UP_W] == '0)
    else $error("upstream reserved bits read nonzero");

  mgmt_read_vector_a: assert property (
    (ce_i && acc.rd_en && acc.sel[SEL_VEC])
    |=> cfg_rdata_o == $past(vec_reg))
    else $error("vector read through management port wrong");

  launch_write_a: assert property (
    (ce_i && acc.wr_en && acc.sel[SEL_LAUNCH])
    |=> launch_reg == $past(cfg_wdata_i[LAUNCH_BIT]))
    else $error("launch bit write not stored");

  launch_cv: cover property (
    state_reg == VST_RUN && acc.wr_en && acc.sel[SEL_LAUNCH] &&
    cfg_wdata_i[LAUNCH_BIT] ##2 launched_o);
  foreign_cv: cover property (cfg_req_i && !acc.path_ok ##1 cfg_ack_o);
  hot_reset_cv: cover property (state_reg == VST_RUN && hot_reset_i);
  unlaunched_cv: cover property (
    state_reg == VST_LOAD && ce_i && virtual_switch_mode_input_next && !launch_next);
  eeprom_cv: cover property (virtual_switch_mode_input_reg && acc.wr_en && cfg_from_eeprom_i);

endmodule : vst_regs

// ---- testbench/tb.sv ----
`timescale 1ns/1ns
module tb;
  import vst_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i, ce, hot, i2cn, mgz, vsm, vsz, req, wr, via, ee;
  logic ack, lch, vmo, k0;
  logic [2:0] nts, ntz, tms;
  logic [ADDR_W-1:0] adr;
  logic [DATA_W-1:0] wd, rdat, mem, q0;
  logic [5:0] en, ten;
  logic [24:0] tup;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // strap pins, floating pins, decoded port
  logic [2:0] lv [5] = '{3'h3, 3'h0, 3'h1, 3'h7, 3'h6};
  logic [2:0] fz [5] = '{3'h0, 3'h1, 3'h4, 3'h0, 3'h0};
  logic [4:0] pn [5] = '{5'h08, 5'h01, 5'h0b, 5'h1f, 5'h00};

  vst_regs dut (
    .clk_i, .rstn_i, .ce_i(ce), .hot_reset_i(hot),
    .i2c_config_allow_strap_n_i(i2cn),
    .management_port_enable_strap_z_i(mgz),
    .nontransparent_uplink_select_strap_i(nts),
    .nontransparent_uplink_select_strap_z_i(ntz),
    .test_mode_strap_i(tms), .virtual_switch_mode_input_i(vsm),
    .virtual_switch_mode_input_z_i(vsz), .cfg_req_i(req),
    .cfg_wr_i(wr), .cfg_addr_i(adr), .cfg_wdata_i(wd),
    .cfg_via_mgmt_i(via), .cfg_from_eeprom_i(ee), .cfg_ack_o(ack),
    .cfg_rdata_o(rdat), .virtual_switch_enable_bit_i(en),
    .table_upstream_o(tup), .table_members_o(mem),
    .table_enable_o(ten), .launched_o(lch), .virtual_switch_mode_input_o(vmo));

  vst_host_model host (
    .clk_i, .ack_i(ack), .rdata_i(rdat), .req_o(req), .wr_o(wr),
    .addr_o(adr), .wdata_o(wd), .mgmt_o(via), .eeprom_o(ee));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic final_report();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // hang guard, well above the ~180 cycles the sequence needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rd(input logic [11:0] a, input logic v,
                    input logic [31:0] e);
    host.access(1'b0, a, 32'h0, v, 1'b0, q0, k0);
    chk("ack", 32'h1, {31'h0, k0});
    chk($sformatf("read %h", a), e, q0);
  endtask : rd

  task automatic wt(input logic [11:0] a, input logic [31:0] d,
                    input logic v, input logic x);
    host.access(1'b1, a, d, v, x, q0, k0);
    chk("ack", 32'h1, {31'h0, k0});
  endtask : wt

  // straps are captured on the first edge after release
  task automatic boot();
    @(negedge clk_i);
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rstn_i = 1'b1;
  endtask : boot

  initial begin
    rstn_i = 1'b0;
    ce = 1'b1;
    hot = 1'b0;
    i2cn = 1'b1;
    mgz = 1'b0;
    tms = 3'h0;
    en = 6'h00;
    // floating mode pin must still mean base mode
    vsm = 1'b1;
    vsz = 1'b1;
    for (int i = 0; i < 5; i++) begin
      nts = lv[i];
      ntz = fz[i];
      boot();
      for (int r = 0; r < 5; r++) begin
        rd(OFF_VS1_UP + 12'(4 * r), 1'b1, {27'h0, pn[i]});
      end
      rd(OFF_MEMBER_VEC, 1'b1, VEC_ALL_PORTS);
      rd(OFF_LAUNCH, 1'b1, 32'h1);
      chk("virtual_switch_mode_input", 32'h0, {31'h0, vmo});
    end
    wt(OFF_VS2_UP, 32'hffff_ffea, 1'b1, 1'b0);
    rd(OFF_VS2_UP, 1'b1, 32'h0000_000a);
    wt(OFF_MEMBER_VEC, 32'h0, 1'b1, 1'b0);
    rd(OFF_MEMBER_VEC, 1'b1, 32'h00ff_f0f0);
    wt(12'h3b0, 32'hffff_ffff, 1'b1, 1'b0);
    rd(12'h3b0, 1'b1, 32'h0);
    vsz = 1'b0;
    nts = 3'h3;
    ntz = 3'h0;
    for (int t = 0; t < 8; t++) begin
      tms = 3'(t);
      boot();
      rd(OFF_MEMBER_VEC, 1'b1, VEC_TM_RST[t]);
      chk("virtual_switch_mode_input", 32'h1, {31'h0, vmo});
    end
    for (int j = 0; j < 2; j++) begin
      i2cn = 1'(j);
      mgz = 1'(j);
      boot();
      rd(OFF_LAUNCH, 1'b1, 32'h0);
      rd(OFF_MEMBER_VEC, 1'b1, VEC_ALL_PORTS);
    end
    chk("tbl_up", 32'h0, {7'h0, tup});
    wt(OFF_VS1_UP, 32'h5, 1'b0, 1'b0);
    rd(OFF_VS1_UP, 1'b0, 32'h0);
    rd(OFF_VS1_UP, 1'b1, 32'h8);
    wt(OFF_VS1_UP, 32'h13, 1'b0, 1'b1);
    rd(OFF_VS1_UP, 1'b1, 32'h13);
    en = 6'h2a;
    wt(OFF_LAUNCH, 32'h1, 1'b1, 1'b0);
    repeat (2) @(negedge clk_i);
    chk("launched", 32'h1, {31'h0, lch});
    chk("tbl_up", {7'h0, {4{5'h08}}, 5'h13}, {7'h0, tup});
    chk("tbl_mem", VEC_ALL_PORTS, mem);
    chk("tbl_en", 32'h2a, {26'h0, ten});
    wt(OFF_VS4_UP, 32'h11, 1'b1, 1'b0);
    en = 6'h15;
    hot = 1'b1;
    @(negedge clk_i);
    hot = 1'b0;
    @(negedge clk_i);
    chk("tbl_up", {12'h008, 5'h11, 10'h108, 5'h13}, {7'h0, tup});
    chk("tbl_en", 32'h15, {26'h0, ten});
    rd(OFF_VS1_UP, 1'b1, 32'h13);
    // a frozen clock enable must swallow the request
    // let the last ack drop first, or the freeze holds it high
    @(negedge clk_i);
    ce = 1'b0;
    host.access(1'b1, OFF_VS1_UP, 32'h3, 1'b1, 1'b0, q0, k0);
    chk("ack", 32'h0, {31'h0, k0});
    ce = 1'b1;
    rd(OFF_VS1_UP, 1'b1, 32'h13);
    final_report();
  end
endmodule : tb

// ---- testbench/vst_host_model.sv ----
`timescale 1ns/1ns
module vst_host_model (
  // clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [vst_pkg::DATA_W-1:0] rdata_i,
  // request
  output logic req_o,
  output logic wr_o,
  output logic [vst_pkg::ADDR_W-1:0] addr_o,
  output logic [vst_pkg::DATA_W-1:0] wdata_o,
  output logic mgmt_o,
  output logic eeprom_o
);
  import vst_pkg::*;

  initial begin
    req_o = 1'b0;
    wr_o = 1'b0;
    addr_o = '0;
    wdata_o = '0;
    mgmt_o = 1'b1;
    eeprom_o = 1'b0;
  end

  // one request per call, launched and dropped on falling edges
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic v,
                        input logic x, output logic [DATA_W-1:0] q,
                        output logic k);
    @(negedge clk_i);
    req_o = 1'b1;
    wr_o = w;
    addr_o = a;
    wdata_o = d;
    mgmt_o = v;
    eeprom_o = x;
    @(negedge clk_i);
    k = ack_i;
    q = rdata_i;
    req_o = 1'b0;
    // released bus must not keep showing the last value
    addr_o = ~a;
    wdata_o = ~d;
  endtask : access
endmodule : vst_host_model
